// ---- aao_map.vh ----
// constants for the arithmetic and logic datapath
`ifndef AAO_MAP_VH
`define AAO_MAP_VH

// =============================================================
// operation codes
`define AAO_OP_W               4
`define AAO_ADD_REG_OP         4'h0
`define AAO_ADD_CARRY_REG_OP   4'h1
`define AAO_ADD_IMM_WORD_OP    4'h2
`define AAO_SUB_REG_OP         4'h3
`define AAO_SUB_IMM_OP         4'h4
`define AAO_SUB_CARRY_REG_OP   4'h5
`define AAO_SUB_CARRY_IMM_OP   4'h6
`define AAO_SUB_IMM_WORD_OP    4'h7
`define AAO_AND_REG_OP         4'h8
`define AAO_AND_IMM_OP         4'h9
`define AAO_OR_REG_OP          4'hA
`define AAO_OR_IMM_OP          4'hB
`define AAO_XOR_REG_OP         4'hC
`define AAO_SET_BITS_OP        4'hD
`define AAO_CLEAR_BITS_OP      4'hE
`define AAO_ZERO_MINUS_TEST_OP 4'hF

// =============================================================
// flag register bit positions
`define AAO_FLG_C 0
`define AAO_FLG_Z 1
`define AAO_FLG_N 2
`define AAO_FLG_V 3
`define AAO_FLG_S 4
`define AAO_FLG_H 5
`define AAO_FLG_T 6
`define AAO_FLG_I 7

// =============================================================
// reset values
`define AAO_FLAGS_RST  8'h00
`define AAO_RESULT_RST 16'h0000

// =============================================================
// register port offsets
`define AAO_ADDR_W     2
`define AAO_OFS_FLAGS  2'h0
`define AAO_OFS_STATUS 2'h1
`define AAO_OFS_RES_LO 2'h2
`define AAO_OFS_RES_HI 2'h3

// status register fields
`define AAO_STS_BUSY 0
`define AAO_STS_WIDE 1

// =============================================================
// timing in core clocks
`define AAO_BYTE_CYCLES 1
`define AAO_WORD_CYCLES 2

`endif

// ---- aao_addsub.v ----
// eight-bit adder and subtractor slice with flag terms
`timescale 1ns/1ps

module aao_addsub (
	input  wire [7:0] a_i,
	input  wire [7:0] b_i,
	input  wire       cin_i,
	input  wire       sub_i,
	output wire [7:0] r_o,
	output wire       cout_o,
	output wire       half_o,
	output wire       ovf_o
);

	wire [8:0] sum9;
	wire [4:0] sum5;

	// subtraction yields borrow in bit 8 and bit 4
	assign sum9 = sub_i ? ({1'b0, a_i} - {1'b0, b_i} - {8'h00, cin_i})
	                    : ({1'b0, a_i} + {1'b0, b_i} + {8'h00, cin_i});
	assign sum5 = sub_i ? ({1'b0, a_i[3:0]} - {1'b0, b_i[3:0]}
	                       - {4'h0, cin_i})
	                    : ({1'b0, a_i[3:0]} + {1'b0, b_i[3:0]}
	                       + {4'h0, cin_i});

	assign r_o    = sum9[7:0];
	assign cout_o = sum9[8];
	assign half_o = sum5[4];
	assign ovf_o  = sub_i ?
		((a_i[7] & ~b_i[7] & ~sum9[7]) | (~a_i[7] & b_i[7] & sum9[7])) :
		((a_i[7] & b_i[7] & ~sum9[7]) | (~a_i[7] & ~b_i[7] & sum9[7]));

endmodule

// ---- aao_alu_ops.v ----
// arithmetic and logic datapath with flag register and register port
//
// Overview of operation
// RULE1 - add registers plus carry, flags, one clock
// RULE2 - add immediate to register pair, two clocks
// RULE3 - subtract immediate from register, one clock
// RULE4 - subtract register and carry, one clock
// RULE5 - subtract immediate and carry, one clock
// RULE6 - subtract immediate from register pair, two clocks
// RULE7 - and with immediate, flags Z N V
// RULE8 - or with immediate, flags Z N V
// RULE9 - set bits by or with mask
// RULE10 - clear bits by and with inverted mask
// RULE11 - test register by and with itself
// RULE12 - zero on all-zero result, negative is top bit
// RULE13 - logic clears overflow, sign is N xor V (the code updates S only on the two word operations)
`timescale 1ns/1ps
`include "aao_map.vh"

module aao_alu_ops #(
	parameter DATA_W = 8
) (
	input  wire                   clk_i,
	input  wire                   nrst_i,
	input  wire                   start_i,
	input  wire [`AAO_OP_W-1:0]   op_i,
	input  wire [DATA_W-1:0]      dst_i,
	input  wire [DATA_W-1:0]      dst_hi_i,
	input  wire [DATA_W-1:0]      src_reg_i,
	input  wire [DATA_W-1:0]      imm_i,
	input  wire [`AAO_ADDR_W-1:0] addr_i,
	input  wire [7:0]             wdata_i,
	input  wire                   wr_i,
	input  wire                   rd_i,
	output reg  [7:0]             rdata_o,
	output reg  [2*DATA_W-1:0]    result_o,
	output reg                    done_o,
	output reg                    wide_o,
	output reg                    busy_o,
	output reg  [7:0]             flags_o
);

	// =========================================================
	// state machine codes
	localparam ST_IDLE    = 1'b0;
	localparam ST_WORD_HI = 1'b1;

	reg                state;
	reg [DATA_W-1:0]   lo_q;
	reg                lo_carry_q;
	reg [DATA_W-1:0]   dst_hi_q;
	reg                word_sub_q;

	// =========================================================
	// operation decode
	reg                is_word;
	reg                is_arith;
	reg                is_logic;
	reg                op_sub;
	reg                use_carry;
	reg                use_imm;
	reg [DATA_W-1:0]   logic_res;

	always @* begin
		is_word   = 1'b0;
		is_arith  = 1'b0;
		is_logic  = 1'b0;
		op_sub    = 1'b0;
		use_carry = 1'b0;
		use_imm   = 1'b0;
		logic_res = dst_i;
		case (op_i)
			`AAO_ADD_REG_OP: begin
				is_arith = 1'b1;
			end
			`AAO_ADD_CARRY_REG_OP: begin
				is_arith  = 1'b1;
				use_carry = 1'b1; // RULE1
			end
			`AAO_ADD_IMM_WORD_OP: begin
				is_word = 1'b1; // RULE2
				use_imm = 1'b1;
			end
			`AAO_SUB_REG_OP: begin
				is_arith = 1'b1;
				op_sub   = 1'b1;
			end
			`AAO_SUB_IMM_OP: begin
				is_arith = 1'b1; // RULE3
				op_sub   = 1'b1;
				use_imm  = 1'b1;
			end
			`AAO_SUB_CARRY_REG_OP: begin
				is_arith  = 1'b1; // RULE4
				op_sub    = 1'b1;
				use_carry = 1'b1;
			end
			`AAO_SUB_CARRY_IMM_OP: begin
				is_arith  = 1'b1; // RULE5
				op_sub    = 1'b1;
				use_carry = 1'b1;
				use_imm   = 1'b1;
			end
			`AAO_SUB_IMM_WORD_OP: begin
				is_word = 1'b1; // RULE6
				op_sub  = 1'b1;
				use_imm = 1'b1;
			end
			`AAO_AND_REG_OP: begin
				is_logic  = 1'b1;
				logic_res = dst_i & src_reg_i;
			end
			`AAO_AND_IMM_OP: begin
				is_logic  = 1'b1;
				logic_res = dst_i & imm_i; // RULE7
			end
			`AAO_OR_REG_OP: begin
				is_logic  = 1'b1;
				logic_res = dst_i | src_reg_i;
			end
			`AAO_OR_IMM_OP: begin
				is_logic  = 1'b1;
				logic_res = dst_i | imm_i; // RULE8
			end
			`AAO_XOR_REG_OP: begin
				is_logic  = 1'b1;
				logic_res = dst_i ^ src_reg_i;
			end
			`AAO_SET_BITS_OP: begin
				is_logic  = 1'b1;
				logic_res = dst_i | imm_i; // RULE9
			end
			`AAO_CLEAR_BITS_OP: begin
				is_logic  = 1'b1;
				logic_res = dst_i & ~imm_i; // RULE10
			end
			default: begin
				is_logic  = 1'b1;
				logic_res = dst_i & dst_i; // RULE11
			end
		endcase
	end

	// =========================================================
	// shared adder slice
	reg  [DATA_W-1:0]  slice_a;
	reg  [DATA_W-1:0]  slice_b;
	reg                slice_cin;
	reg                slice_sub;
	wire [DATA_W-1:0]  slice_r;
	wire               slice_cout;
	wire               slice_half;
	wire               slice_ovf;

	always @* begin
		if (state == ST_WORD_HI) begin
			// high byte takes the carry or borrow of the low byte
			slice_a   = dst_hi_q;
			slice_b   = {DATA_W{1'b0}};
			slice_cin = lo_carry_q;
			slice_sub = word_sub_q;
		end else begin
			slice_a   = dst_i;
			slice_b   = use_imm ? imm_i : src_reg_i;
			slice_cin = use_carry & flags_o[`AAO_FLG_C];
			slice_sub = op_sub;
		end
	end

	aao_addsub u_slice (
		.a_i    (slice_a),
		.b_i    (slice_b),
		.cin_i  (slice_cin),
		.sub_i  (slice_sub),
		.r_o    (slice_r),
		.cout_o (slice_cout),
		.half_o (slice_half),
		.ovf_o  (slice_ovf)
	);

	// =========================================================
	// flag and result computation
	wire               take;
	reg                hw_upd;
	reg  [7:0]         hw_flags;
	reg  [2*DATA_W-1:0] next_result;
	reg                next_done;
	reg                next_wide;

	assign take = start_i & (state == ST_IDLE);

	always @* begin
		hw_upd      = 1'b0;
		hw_flags    = flags_o;
		next_result = result_o;
		next_done   = 1'b0;
		next_wide   = wide_o;
		if (state == ST_WORD_HI) begin
			hw_upd      = 1'b1;
			next_done   = 1'b1;
			next_wide   = 1'b1;
			next_result = {slice_r, lo_q};
			hw_flags[`AAO_FLG_Z] = ({slice_r, lo_q} == 0); // RULE12
			hw_flags[`AAO_FLG_C] = slice_cout; // RULE2 RULE6
			hw_flags[`AAO_FLG_N] = slice_r[DATA_W-1]; // RULE12
			hw_flags[`AAO_FLG_V] = slice_ovf;
			hw_flags[`AAO_FLG_S] = slice_r[DATA_W-1] ^ slice_ovf; // RULE13
		end else if (take && is_arith) begin
			hw_upd      = 1'b1;
			next_done   = 1'b1;
			next_wide   = 1'b0;
			next_result = {{DATA_W{1'b0}}, slice_r};
			hw_flags[`AAO_FLG_Z] = (slice_r == 0); // RULE12
			hw_flags[`AAO_FLG_C] = slice_cout; // RULE1 RULE3 RULE4 RULE5
			hw_flags[`AAO_FLG_N] = slice_r[DATA_W-1]; // RULE12
			hw_flags[`AAO_FLG_V] = slice_ovf;
			hw_flags[`AAO_FLG_H] = slice_half;
		end else if (take && is_logic) begin
			hw_upd      = 1'b1;
			next_done   = 1'b1;
			next_wide   = 1'b0;
			next_result = {{DATA_W{1'b0}}, logic_res};
			hw_flags[`AAO_FLG_Z] = (logic_res == 0); // RULE12
			hw_flags[`AAO_FLG_N] = logic_res[DATA_W-1]; // RULE12
			hw_flags[`AAO_FLG_V] = 1'b0; // RULE13
		end
	end

	// =========================================================
	// sequencing of one and two clock operations
	reg                next_state;
	reg                next_busy;
	reg  [DATA_W-1:0]  next_lo;
	reg                next_lo_carry;
	reg  [DATA_W-1:0]  next_dst_hi;
	reg                next_word_sub;

	always @* begin
		next_state    = state;
		next_busy     = busy_o;
		next_lo       = lo_q;
		next_lo_carry = lo_carry_q;
		next_dst_hi   = dst_hi_q;
		next_word_sub = word_sub_q;
		case (state)
			ST_IDLE: begin
				if (take && is_word) begin
					// low byte now, high byte next clock
					next_lo       = slice_r; // RULE2 RULE6
					next_lo_carry = slice_cout;
					next_dst_hi   = dst_hi_i;
					next_word_sub = op_sub;
					next_busy     = 1'b1;
					next_state    = ST_WORD_HI;
				end
			end
			default: begin
				next_busy  = 1'b0;
				next_state = ST_IDLE;
			end
		endcase
	end

	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state      <= ST_IDLE;
			lo_q       <= {DATA_W{1'b0}};
			lo_carry_q <= 1'b0;
			dst_hi_q   <= {DATA_W{1'b0}};
			word_sub_q <= 1'b0;
			busy_o     <= 1'b0;
		end else begin
			state      <= next_state;
			lo_q       <= next_lo;
			lo_carry_q <= next_lo_carry;
			dst_hi_q   <= next_dst_hi;
			word_sub_q <= next_word_sub;
			busy_o     <= next_busy;
		end
	end

	// =========================================================
	// flag register, datapath update wins over a software write
	wire               flags_wr;
	reg  [7:0]         next_flags;

	assign flags_wr = wr_i && (addr_i == `AAO_OFS_FLAGS);

	always @* begin
		if (hw_upd) begin
			next_flags = hw_flags;
		end else if (flags_wr) begin
			next_flags = wdata_i;
		end else begin
			next_flags = flags_o;
		end
	end

	// =========================================================
	// result and flag registers
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			result_o <= `AAO_RESULT_RST;
			done_o   <= 1'b0;
			wide_o   <= 1'b0;
			flags_o  <= `AAO_FLAGS_RST;
		end else begin
			result_o <= next_result;
			done_o   <= next_done;
			wide_o   <= next_wide;
			flags_o  <= next_flags;
		end
	end

	// =========================================================
	// register port read data, valid one cycle after the strobe
	reg  [7:0]         status_word;
	reg  [7:0]         next_rdata;

	always @* begin
		status_word                = 8'h00;
		status_word[`AAO_STS_BUSY] = busy_o;
		status_word[`AAO_STS_WIDE] = wide_o;
	end

	always @* begin
		next_rdata = 8'h00;
		if (!rd_i) begin
			next_rdata = 8'h00;
		end else if (addr_i == `AAO_OFS_FLAGS) begin
			next_rdata = flags_o;
		end else if (addr_i == `AAO_OFS_STATUS) begin
			next_rdata = status_word;
		end else if (addr_i == `AAO_OFS_RES_LO) begin
			next_rdata = result_o[7:0];
		end else begin
			next_rdata = result_o[15:8];
		end
	end

	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rdata_o <= 8'h00;
		end else begin
			rdata_o <= next_rdata;
		end
	end

endmodule

// ---- aao_alu_chk_asserts.sv ----
// timing and flag checker for the alu datapath
`timescale 1ns/1ps
`include "aao_map.vh"
// =====
// checker
module aao_alu_chk (
	input wire        clk_i,
	input wire        nrst_i,
	input wire        start_i,
	input wire [3:0]  op_i,
	input wire [15:0] result_o,
	input wire        done_o,
	input wire        wide_o,
	input wire        busy_o,
	input wire [7:0]  flags_o
);
	wire tk = start_i && !busy_o;
	wire wd = op_i == `AAO_ADD_IMM_WORD_OP ||
		op_i == `AAO_SUB_IMM_WORD_OP;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	chk_byte_time: assert property (
		tk && !wd |=> done_o && !wide_o && !busy_o) else $error("byte late");
	chk_word_time: assert property (
		tk && wd |=> busy_o && !done_o ##1 done_o && wide_o && !busy_o)
		else $error("word late");
	chk_zero_flag: assert property (
		done_o |-> flags_o[1] == (wide_o ? result_o == 16'h0000 :
		result_o[7:0] == 8'h00)) else $error("zero flag");
	chk_neg_flag: assert property (
		done_o |-> flags_o[2] == result_o[wide_o ? 15 : 7])
		else $error("negative flag");
	chk_byte_upper: assert property (
		done_o && !wide_o |-> result_o[15:8] == 8'h00) else $error("upper");
	chk_word_sign: assert property (
		done_o && wide_o |-> flags_o[4] == (flags_o[2] ^ flags_o[3]))
		else $error("sign flag");
	chk_logic_kept: assert property (
		tk && op_i[3] |=> !flags_o[3] && $stable(flags_o[0]) &&
		$stable(flags_o[5])) else $error("logic flags");
	chk_arith_skept: assert property (
		tk && !op_i[3] && !wd |=> $stable(flags_o[4])) else $error("s kept");
	chk_word_hkept: assert property (
		tk && wd |=> ##1 $stable(flags_o[5])) else $error("h kept");
endmodule

bind aao_alu_ops aao_alu_chk chk_u (.clk_i(clk_i), .nrst_i(nrst_i),
	.start_i(start_i), .op_i(op_i), .result_o(result_o), .done_o(done_o),
	.wide_o(wide_o), .busy_o(busy_o), .flags_o(flags_o));

// ---- aao_dec_model.sv ----
// decoder and register file stand-in issuing operations
`timescale 1ns/1ps
`include "aao_map.vh"
// =====
// issuer
module aao_dec_model (
	input  wire       clk_i,
	input  wire       go_i,
	input  wire [3:0] op_i,
	input  wire [7:0] a_i,
	input  wire [7:0] h_i,
	input  wire [7:0] b_i,
	output reg        start_o = 1'b0,
	output reg  [3:0] op_o = 4'h0,
	output reg  [7:0] dst_o = 8'h00,
	output reg  [7:0] hi_o = 8'h00,
	output reg  [7:0] b_o = 8'h00,
	output reg  [7:0] k_o = 8'h00
);
	// immediate ops get the constant, the unused port its inverse
	wire k_op = op_i == `AAO_ADD_IMM_WORD_OP ||
		op_i == `AAO_SUB_IMM_OP || op_i == `AAO_SUB_CARRY_IMM_OP ||
		op_i == `AAO_SUB_IMM_WORD_OP || op_i == `AAO_AND_IMM_OP ||
		op_i == `AAO_OR_IMM_OP || op_i == `AAO_SET_BITS_OP ||
		op_i == `AAO_CLEAR_BITS_OP;
	// operands toggle outside the issue cycle
	always @(posedge clk_i) begin
		start_o <= go_i;
		if (go_i) begin
			op_o <= op_i;
			dst_o <= a_i;
			hi_o <= h_i;
			b_o <= k_op ? ~b_i : b_i;
			k_o <= k_op ? b_i : ~b_i;
		end else begin
			dst_o <= ~dst_o;
			hi_o <= ~hi_o;
			b_o <= ~b_o;
			k_o <= ~k_o;
		end
	end
endmodule

// ---- aao_alu_ops_tb.sv ----
// self-checking testbench for the alu datapath
`timescale 1ns/1ps
`include "aao_map.vh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin num_errors++; \
	$display("ERROR t=%0t got %h exp %h", $time, g, e); end end
// =====
// bench
module aao_alu_ops_tb;
	reg         clk_i = 0, nrst_i = 0, go = 0, wr_i = 0, rd_i = 0;
	reg  [3:0]  gop = 0;
	reg  [7:0]  ga = 0, gh = 0, gb = 0, wdata_i = 0, ef = 0;
	reg  [1:0]  addr_i = 0;
	reg  [23:0] ex;
	wire        start_i, busy_o, done_o, wide_o;
	wire [3:0]  op_i;
	wire [7:0]  dst_i, dst_hi_i, src_reg_i, imm_i, rdata_o, flags_o;
	wire [15:0] result_o;
	integer     num_errors = 0, checked = 0, cyc = 0;
	aao_dec_model dec_u (.clk_i(clk_i), .go_i(go), .op_i(gop), .a_i(ga),
		.h_i(gh), .b_i(gb), .start_o(start_i), .op_o(op_i),
		.dst_o(dst_i), .hi_o(dst_hi_i), .b_o(src_reg_i), .k_o(imm_i));
	aao_alu_ops dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .start_i(start_i),
		.op_i(op_i), .dst_i(dst_i), .dst_hi_i(dst_hi_i),
		.src_reg_i(src_reg_i), .imm_i(imm_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.result_o(result_o), .done_o(done_o), .wide_o(wide_o),
		.busy_o(busy_o), .flags_o(flags_o));
	// expected flags and result
	function [23:0] calc(input [3:0] o, input [7:0] a, h, b, f);
		reg [8:0]  r;
		reg [16:0] w;
		reg [7:0]  g;
		reg        c, s;
		begin
			g = f;
			c = f[0];
			r = 9'h000;
			s = o == `AAO_SUB_IMM_WORD_OP;
			if (o == `AAO_ADD_IMM_WORD_OP || s) begin
				w = s ? {h, a} - b : {h, a} + b;
				g[0] = w[16];
				g[3] = s ? h[7] & !w[15] : !h[7] & w[15];
				g[1] = w[15:0] == 16'h0000;
				g[2] = w[15];
				g[4] = g[2] ^ g[3];
				calc = {g, w[15:0]};
			end else begin
				if (o == `AAO_SUB_IMM_OP || o == `AAO_ADD_REG_OP ||
					o == `AAO_SUB_REG_OP)
					c = 1'b0;
				case (o)
				`AAO_ADD_CARRY_REG_OP, `AAO_ADD_REG_OP: begin
					r = a + b + c;
					g[5] = a[3:0] + b[3:0] + c > 15;
					g[3] = a[7] == b[7] && r[7] != a[7];
				end
				`AAO_SUB_IMM_OP, `AAO_SUB_CARRY_REG_OP,
				`AAO_SUB_CARRY_IMM_OP, `AAO_SUB_REG_OP: begin
					r = a - b - c;
					g[5] = {1'b0, a[3:0]} < {1'b0, b[3:0]} + c;
					g[3] = a[7] != b[7] && r[7] != a[7];
				end
				`AAO_AND_IMM_OP, `AAO_AND_REG_OP: r = a & b;
				`AAO_XOR_REG_OP: r = a ^ b;
				`AAO_CLEAR_BITS_OP: r = a & ~b;
				`AAO_ZERO_MINUS_TEST_OP: r = a & a;
				default: r = a | b;
				endcase
				if (o[3])
					g[3] = 1'b0;
				else
					g[0] = r[8];
				g[1] = r[7:0] == 8'h00;
				g[2] = r[7];
				calc = {g, 8'h00, r[7:0]};
			end
		end
	endfunction
	task stop_test;
		begin
			$display("errors %0d checks %0d", num_errors, checked);
			if (num_errors == 0 && checked > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask
	task wr(input [1:0] a, input [7:0] d);
		begin
			@(posedge clk_i);
			addr_i <= a;
			wdata_i <= d;
			wr_i <= 1'b1;
			@(posedge clk_i);
			wr_i <= 1'b0;
			if (a == `AAO_OFS_FLAGS)
				ef = d;
		end
	endtask
	task rd(input [1:0] a, input [7:0] e);
		begin
			@(posedge clk_i);
			addr_i <= a;
			rd_i <= 1'b1;
			@(posedge clk_i);
			rd_i <= 1'b0;
			#1;
			`CHK(rdata_o, e)
		end
	endtask
	task run(input [3:0] o, input [7:0] a, h, b);
		integer n;
		begin
			ex = calc(o, a, h, b, ef);
			@(posedge clk_i);
			{gop, ga, gh, gb} <= {o, a, h, b};
			go <= 1'b1;
			@(posedge clk_i);
			go <= 1'b0;
			for (n = 0; n < 8; n = n + 1) begin
				@(posedge clk_i);
				#1;
				if (done_o === 1'b1)
					n = 8;
			end
			`CHK(done_o, 1'b1)
			`CHK(result_o, ex[15:0])
			`CHK(flags_o, ex[23:16])
			ef = ex[23:16];
		end
	endtask
	initial forever #25 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc = cyc + 1;
		if (cyc == 2000) begin
			num_errors++;
			stop_test;
		end
	end
	initial begin
		repeat (16) @(posedge clk_i);
		nrst_i <= 1'b1;
		rd(`AAO_OFS_FLAGS, `AAO_FLAGS_RST);
		wr(`AAO_OFS_FLAGS, 8'h01);
		rd(`AAO_OFS_FLAGS, 8'h01);
		run(`AAO_ADD_CARRY_REG_OP, 8'hFF, 8'h00, 8'h00);
		run(`AAO_ADD_CARRY_REG_OP, 8'h7F, 8'h00, 8'h00);
		run(`AAO_SUB_IMM_OP, 8'h10, 8'h00, 8'h01);
		wr(`AAO_OFS_FLAGS, 8'h01);
		run(`AAO_SUB_CARRY_REG_OP, 8'h00, 8'h00, 8'h00);
		run(`AAO_SUB_CARRY_IMM_OP, 8'h80, 8'h00, 8'h7F);
		run(`AAO_ADD_IMM_WORD_OP, 8'hFF, 8'h7F, 8'h01);
		rd(`AAO_OFS_RES_LO, 8'h00);
		rd(`AAO_OFS_RES_HI, 8'h80);
		wr(`AAO_OFS_STATUS, 8'hFF);
		rd(`AAO_OFS_STATUS, 8'h02);
		run(`AAO_ADD_IMM_WORD_OP, 8'hFF, 8'hFF, 8'h01);
		run(`AAO_ADD_REG_OP, 8'h0F, 8'h00, 8'h01);
		run(`AAO_SUB_IMM_WORD_OP, 8'h00, 8'h80, 8'h01);
		run(`AAO_AND_IMM_OP, 8'hF0, 8'h00, 8'h0F);
		run(`AAO_SUB_IMM_WORD_OP, 8'h00, 8'h00, 8'h01);
		run(`AAO_SUB_REG_OP, 8'h05, 8'h00, 8'h05);
		run(`AAO_AND_REG_OP, 8'h3C, 8'h00, 8'h0F);
		run(`AAO_OR_REG_OP, 8'h00, 8'h00, 8'h80);
		run(`AAO_XOR_REG_OP, 8'hAA, 8'h00, 8'hAA);
		run(`AAO_OR_IMM_OP, 8'h81, 8'h00, 8'h10);
		run(`AAO_SET_BITS_OP, 8'h00, 8'h00, 8'h00);
		run(`AAO_CLEAR_BITS_OP, 8'hFF, 8'h00, 8'h0F);
		run(`AAO_ZERO_MINUS_TEST_OP, 8'h80, 8'h00, 8'h00);
		stop_test;
	end
endmodule
